// >>> ccms_bank.sv
// ccms_bank: holds configuration words 03h..0Eh, assembles ten 17-bit
// sign-magnitude calibration coefficients for the correction datapath.
// assumes host word writes/reads are synchronous to ref_clk.
`default_nettype none
module ccms_bank
    import ccms_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host word access to the configuration memory
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wr_data,
    output logic [WORD_W-1:0] rd_data,
    output logic rd_valid,
    // assembled coefficients, index order per package
    output logic [NUM_COEF*COEF_W-1:0] coef_mag,
    output logic [NUM_COEF-1:0] coef_neg,
    // single-bit controls
    output logic curve_shape_select,
    output logic settle_temp_term_neg
);
    logic [WORD_W-1:0] msb_bridge_r;
    logic [WORD_W-1:0] msb_bridge_nxt;
    logic [TEMP_USED_W-1:0] msb_temp_r;
    logic [TEMP_USED_W-1:0] msb_temp_nxt;
    logic [WORD_W-1:0] low_r [NUM_COEF];
    logic [WORD_W-1:0] low_nxt [NUM_COEF];
    logic [WORD_W-1:0] rd_data_r;
    logic [WORD_W-1:0] rd_data_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;
    logic ctl_r;
    logic ctl_nxt;
    logic settle_r;
    logic settle_nxt;
    logic [ADDR_W-1:0] low_idx;

    always_comb begin
        low_idx = addr - ADDR_LOW_FIRST;
        msb_bridge_nxt = msb_bridge_r;
        msb_temp_nxt = msb_temp_r;
        for (int i = 0; i < NUM_COEF; i++) begin
            low_nxt[i] = low_r[i];
        end
        if (wr_en) begin
            if (addr == ADDR_MSB_BRIDGE) begin
                msb_bridge_nxt = wr_data;
            end else if (addr == ADDR_MSB_TEMP) begin
                // unused upper bits not stored
                msb_temp_nxt = wr_data[TEMP_USED_W-1:0];
            end else if (addr >= ADDR_LOW_FIRST && addr <= ADDR_LOW_LAST) begin
                low_nxt[low_idx[3:0]] = wr_data;
            end
        end
        rd_valid_nxt = rd_en;
        rd_data_nxt = RESET_WORD;
        if (rd_en) begin
            if (addr == ADDR_MSB_BRIDGE) begin
                rd_data_nxt = msb_bridge_r;
            end else if (addr == ADDR_MSB_TEMP) begin
                rd_data_nxt = {{(WORD_W-TEMP_USED_W){1'b0}}, msb_temp_r};
            end else if (addr >= ADDR_LOW_FIRST && addr <= ADDR_LOW_LAST) begin
                rd_data_nxt = low_r[low_idx[3:0]];
            end
        end
        ctl_nxt = msb_bridge_r[BIT_CURVE_SHAPE];
        settle_nxt = msb_bridge_r[BIT_SETTLE_NEG];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msb_bridge_r <= RESET_WORD;
            msb_temp_r <= '0;
            for (int i = 0; i < NUM_COEF; i++) begin
                low_r[i] <= RESET_WORD;
            end
            rd_data_r <= RESET_WORD;
            rd_valid_r <= 1'b0;
            ctl_r <= 1'b0;
            settle_r <= 1'b0;
        end else begin
            msb_bridge_r <= msb_bridge_nxt;
            msb_temp_r <= msb_temp_nxt;
            for (int i = 0; i < NUM_COEF; i++) begin
                low_r[i] <= low_nxt[i];
            end
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            ctl_r <= ctl_nxt;
            settle_r <= settle_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign curve_shape_select = ctl_r;
    assign settle_temp_term_neg = settle_r;

    // one assembler per coefficient; msb at MSB_POS, sign just above it
    genvar g;
    generate
        for (g = 0; g < NUM_COEF; g++) begin : g_coef
            ccms_coef_if cif ();
            logic msb_bit;
            logic sign_bit;
            if (MSB_WORD_SEL[g]) begin : g_temp
                assign msb_bit = msb_temp_r[MSB_POS[g]];
                assign sign_bit = msb_temp_r[MSB_POS[g]+1];
            end else begin : g_bridge
                assign msb_bit = msb_bridge_r[MSB_POS[g]];
                assign sign_bit = msb_bridge_r[MSB_POS[g]+1];
            end
            ccms_coef_asm u_asm (
                .ref_clk(ref_clk),
                .rst(rst),
                .msb(msb_bit),
                .sign(sign_bit),
                .low(low_r[g]),
                .coef(cif.src)
            );
            assign coef_mag[g*COEF_W +: COEF_W] = cif.mag;
            assign coef_neg[g] = cif.neg;
        end
    endgenerate
endmodule
`default_nettype wire

// >>> ccms_bank_assertions.sv
// ccms_bank_assertions: port checks of the coefficient word bank.
// assumes it is bound to every ccms_bank.
`default_nettype none
module ccms_bank_assertions (
    // bank ports
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic [169:0] coef_mag,
    input wire logic [9:0] coef_neg,
    input wire logic curve_shape_select,
    input wire logic settle_temp_term_neg
);
    timeunit 1ns / 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence wr_b; wr_en && addr == 8'h03; endsequence
    sequence wr_t; wr_en && addr == 8'h04; endsequence
    offset_msb_a: assert property (wr_b |-> ##2 coef_mag[16] == $past(wr_data[0], 2)) else $error("msb");
    offset_sign_a: assert property (wr_b |-> ##2 coef_neg[0] == ($past(wr_data[1], 2) && |coef_mag[16:0]))
        else $error("sign");
    gain_msb_a: assert property (wr_b |-> ##2 coef_mag[33] == $past(wr_data[2], 2)) else $error("gain");
    bridge_sign_a: assert property (wr_b |-> ##2 coef_neg[6] == ($past(wr_data[13], 2) && |coef_mag[118:102]))
        else $error("bridge");
    curve_sel_a: assert property (wr_b |-> ##2 curve_shape_select == $past(wr_data[14], 2)) else $error("curve");
    settle_sign_a: assert property (wr_b |-> ##2 settle_temp_term_neg == $past(wr_data[15], 2))
        else $error("settle");
    temp_offset_a: assert property (wr_t |-> ##2 coef_mag[135] == $past(wr_data[4], 2)) else $error("temp");
    temp_unused_a: assert property (rd_en && addr == 8'h04 |=> rd_data[15:6] == 10'h000) else $error("unused");
endmodule
bind ccms_bank ccms_bank_assertions ccms_bank_assertions_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .coef_mag(coef_mag),
    .coef_neg(coef_neg),
    .curve_shape_select(curve_shape_select),
    .settle_temp_term_neg(settle_temp_term_neg)
);
`default_nettype wire

// >>> ccms_coef_asm.sv
// ccms_coef_asm: joins msb, low word and sign into one registered
// sign-magnitude coefficient.
// assumes inputs are stable register contents of the same clock domain.
`default_nettype none
module ccms_coef_asm
    import ccms_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // stored fields
    input wire logic msb,
    input wire logic sign,
    input wire logic [WORD_W-1:0] low,
    // assembled coefficient
    ccms_coef_if.src coef
);
    logic [COEF_W-1:0] mag_r;
    logic [COEF_W-1:0] mag_nxt;
    logic neg_r;
    logic neg_nxt;

    always_comb begin
        mag_nxt = {msb, low};
        // zero magnitude never reports negative
        neg_nxt = sign && (mag_nxt != '0);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mag_r <= '0;
            neg_r <= 1'b0;
        end else begin
            mag_r <= mag_nxt;
            neg_r <= neg_nxt;
        end
    end

    assign coef.mag = mag_r;
    assign coef.neg = neg_r;
endmodule
`default_nettype wire

// >>> ccms_coef_if.sv
// ccms_coef_if: carries one assembled sign-magnitude coefficient from the
// assembler leaf back to the register bank.
// assumes a single producer and a single consumer.
`default_nettype none
interface ccms_coef_if import ccms_pkg::*; ();
    logic [COEF_W-1:0] mag;
    logic neg;
    modport src (output mag, output neg);
    modport dst (input mag, input neg);
endinterface
`default_nettype wire

// >>> ccms_host.sv
// ccms_host: calibration host model issuing word writes and reads.
// assumes the bank samples its strobes on the rising edge.
`default_nettype none
module ccms_host (
    // word access
    input wire logic ref_clk,
    output logic wr_en = 1'b0,
    output logic rd_en = 1'b0,
    output logic [7:0] addr = 8'h00,
    output logic [15:0] wr_data = 16'h0000,
    input wire logic [15:0] rd_data
);
    timeunit 1ns / 1ps;
    // strobe left high, so consecutive calls write back to back
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        {wr_en, rd_en, addr, wr_data} = {2'b10, a, d};
    endtask
    // released data lines invert so stale data never looks fresh
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        {wr_en, rd_en, addr, wr_data} = {2'b01, a, ~wr_data};
        @(negedge ref_clk);
        rd_en = 1'b0;
        d = rd_data;
    endtask
endmodule
`default_nettype wire

// >>> ccms_pkg.sv
// ccms_pkg: word addresses, field positions and widths for the coefficient
// msb/sign words and their low words in the configuration memory.
// assumes a 16-bit word-addressed write port from the calibration host.
`default_nettype none
package ccms_pkg;
    localparam int WORD_W = 16;
    localparam int COEF_W = 17;
    localparam int ADDR_W = 8;
    localparam int NUM_COEF = 10;
    // word addresses
    localparam logic [7:0] ADDR_MSB_BRIDGE = 8'h03;
    localparam logic [7:0] ADDR_MSB_TEMP = 8'h04;
    localparam logic [7:0] ADDR_LOW_FIRST = 8'h05;
    localparam logic [7:0] ADDR_LOW_LAST = 8'h0E;
    // reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // coefficient indices, also low-word address minus ADDR_LOW_FIRST
    localparam int C_OFFSET_B = 0;
    localparam int C_GAIN_B = 1;
    localparam int C_TCG = 2;
    localparam int C_TCO = 3;
    localparam int C_SO_OFFSET_DRIFT = 4;
    localparam int C_SO_GAIN_DRIFT = 5;
    localparam int C_SO_BRIDGE = 6;
    localparam int C_OFFSET_T = 7;
    localparam int C_GAIN_T = 8;
    localparam int C_SO_TEMP = 9;
    // word 03h single bits
    localparam int BIT_CURVE_SHAPE = 14;
    localparam int BIT_SETTLE_NEG = 15;
    // word 04h used bits
    localparam int TEMP_USED_W = 6;
    // per coefficient: which msb word (0 = 03h, 1 = 04h) and msb bit position;
    // sign sits at msb position + 1
    localparam logic [9:0] MSB_WORD_SEL = 10'b11_1000_0000;
    localparam int MSB_POS [NUM_COEF] = '{0, 2, 4, 6, 8, 10, 12, 4, 0, 2};
endpackage
`default_nettype wire

// >>> tb_top.sv
// tb_top: bank driven by the host model; coefficients rebuilt here.
// assumes host calls return on a falling edge.
`default_nettype none
module tb_top;
    timeunit 1ns / 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en, rd_en, rd_valid, curve_shape_select, settle_temp_term_neg;
    logic [7:0] addr;
    logic [15:0] wr_data, rd_data, got;
    logic [15:0] low [10] = '{default: 16'h0000};
    logic [169:0] coef_mag;
    logic [9:0] coef_neg;
    int num_errors = 0;
    int check_count = 0;
    always #2.5 ref_clk = ~ref_clk;
    ccms_bank ccms_bank_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .addr(addr),
        .wr_data(wr_data),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .coef_mag(coef_mag),
        .coef_neg(coef_neg),
        .curve_shape_select(curve_shape_select),
        .settle_temp_term_neg(settle_temp_term_neg)
    );
    ccms_host ccms_host_i (
        .ref_clk(ref_clk),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .addr(addr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // last three take msb and sign from word 04h
    task automatic check_all(input logic [15:0] w3, input logic [15:0] w4);
        int pos [10] = '{0, 2, 4, 6, 8, 10, 12, 4, 0, 2};
        logic [15:0] w;
        logic [16:0] m;
        for (int k = 0; k < 10; k++) begin
            w = (k > 6) ? w4 : w3;
            m = {w[pos[k]], low[k]};
            check(coef_mag[k*17+:17], m);
            check(17'(coef_neg[k]), 17'(w[pos[k]+1] && m != 0));
        end
        check(17'(curve_shape_select), 17'(w3[14]));
        check(17'(settle_temp_term_neg), 17'(w3[15]));
    endtask
    initial begin
        #5000;
        num_errors++;
        close_out();
    end
    initial begin
        static logic [15:0] w3 [3] = '{16'h5555, 16'hAAAA, 16'hC001};
        static logic [15:0] w4 [3] = '{16'hFFD5, 16'h002A, 16'h0015};
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        ccms_host_i.rd(8'h03, got);
        check({rd_valid, got}, 17'h10000);
        check_all(16'h0000, 16'h0000);
        // low word 05h stays zero for the zero-magnitude case
        for (int k = 1; k < 10; k++) begin
            low[k] = 16'(k) * 16'h1111;
            ccms_host_i.wr(8'h05 + 8'(k), low[k]);
        end
        for (int p = 0; p < 3; p++) begin
            ccms_host_i.wr(8'h03, w3[p]);
            ccms_host_i.wr(8'h04, w4[p]);
            ccms_host_i.wr(8'hEE, 16'hFFFF);
            ccms_host_i.rd(8'h04, got);
            check({rd_valid, got}, {11'h400, w4[p][5:0]});
            @(negedge ref_clk);
            check_all(w3[p], w4[p]);
        end
        ccms_host_i.rd(8'hEE, got);
        check({rd_valid, got}, 17'h10000);
        // read answer stands one cycle only, then data returns to zero
        @(negedge ref_clk);
        check({rd_valid, rd_data}, 17'h00000);
        close_out();
    end
endmodule
`default_nettype wire
